// [rtl/tci_timer.v]
// Free-running 16-bit counter with two input-capture channels
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "tci_defs.vh"

module tci_timer
(
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Register port
  input  wire [`TCI_ADDR_W-1:0]  regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWrEn,
  input  wire                    regRdEn,
  output reg  [7:0]              regRdData,
  // Processor state
  input  wire                    globalMask,
  input  wire                    haltMode,
  // Pins, absent ones tied high at the top level
  input  wire                    capture_input_one,
  input  wire                    capture_input_two,
  input  wire                    ext_count_clock_pin,
  // Interrupt requests
  output wire                    rolloverIrq,
  output wire                    captureIrq
);

  // ----------------------------------------
  // Control and status state
  // ----------------------------------------
  reg  [7:0]  ctrlOne_q;
  reg  [7:0]  ctrlTwo_q;
  reg  [15:0] count_q;
  reg  [2:0]  presc_q;
  reg         tick_q;
  reg  [7:0]  lowBuf_q;
  reg         lowFrozen_q;
  reg  [15:0] cap1_q;
  reg  [15:0] cap2_q;
  reg         cap1Block_q;
  reg         cap2Block_q;
  reg         rolloverFlag_q;
  reg         cap1Flag_q;
  reg         cap2Flag_q;
  reg         rollArm_q;
  reg         cap1Arm_q;
  reg         cap2Arm_q;
  reg         negFall_q;

  wire        extEdge;
  wire        cap1Edge;
  wire        cap2Edge;

  // ----------------------------------------
  // Decoded fields and accesses
  // ----------------------------------------
  wire [1:0] clkSel       = {ctrlTwo_q[`TCI_C2_CKHI], ctrlTwo_q[`TCI_C2_CKLO]};
  wire       pulseModes   = ctrlTwo_q[`TCI_C2_SPM] | ctrlTwo_q[`TCI_C2_PWM];
  wire       anyAccess    = regWrEn | regRdEn;
  wire       accCntLo     = anyAccess & (regAddr == `TCI_A_CNT_LO);
  wire       accShdLo     = anyAccess & (regAddr == `TCI_A_SHD_LO);
  wire       rdHigh       = regRdEn & ((regAddr == `TCI_A_CNT_HI) ||
                                       (regAddr == `TCI_A_SHD_HI));
  wire       rdLow        = regRdEn & ((regAddr == `TCI_A_CNT_LO) ||
                                       (regAddr == `TCI_A_SHD_LO));
  wire       wrLow        = regWrEn & ((regAddr == `TCI_A_CNT_LO) ||
                                       (regAddr == `TCI_A_SHD_LO));
  wire       rdFlags      = regRdEn & (regAddr == `TCI_A_FLAGS);
  wire       accCap1Lo    = anyAccess & (regAddr == `TCI_A_CAP1_LO);
  wire       accCap2Lo    = anyAccess & (regAddr == `TCI_A_CAP2_LO);
  wire       rdCap1Hi     = regRdEn & (regAddr == `TCI_A_CAP1_HI);
  wire       rdCap2Hi     = regRdEn & (regAddr == `TCI_A_CAP2_HI);
  wire       rdCap1Lo     = regRdEn & (regAddr == `TCI_A_CAP1_LO);
  wire       rdCap2Lo     = regRdEn & (regAddr == `TCI_A_CAP2_LO);

  // ----------------------------------------
  // Input synchronisers and edge detectors
  // ----------------------------------------
  // Capture pins are wired straight in, no direction gating
  tci_edge_sync uExtSync
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .pinIn     (ext_count_clock_pin),
    .riseSel   (ctrlTwo_q[`TCI_C2_EXTEDGE]),
    .edgePulse (extEdge)
  );

  tci_edge_sync uCap1Sync
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .pinIn     (capture_input_one),
    .riseSel   (ctrlOne_q[`TCI_C1_CAP1EDGE]),
    .edgePulse (cap1Edge)
  );

  tci_edge_sync uCap2Sync
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .pinIn     (capture_input_two),
    .riseSel   (ctrlTwo_q[`TCI_C2_CAP2EDGE]),
    .edgePulse (cap2Edge)
  );

  // ----------------------------------------
  // Count enable from prescaler or external clock
  // ----------------------------------------
  reg [2:0] divMask;
  always @*
  begin
    case (clkSel)
      `TCI_CK_DIV2: divMask = `TCI_DIV2_MASK;
      `TCI_CK_DIV4: divMask = `TCI_DIV4_MASK;
      `TCI_CK_DIV8: divMask = `TCI_DIV8_MASK;
      default:      divMask = `TCI_DIV8_MASK;
    endcase
  end

  // Tick is raised on the rising edge and consumed on the falling edge
  wire extSel  = (clkSel == `TCI_CK_EXT);
  wire presTick = ((presc_q & divMask) == divMask);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= 3'h0;
      tick_q  <= 1'b0;
    end
    else if (haltMode)
    begin
      tick_q  <= 1'b0;
    end
    else
    begin
      presc_q <= presc_q + 3'h1;
      // External edges rely on the source keeping four CPU cycles apart
      tick_q  <= extSel ? extEdge : presTick;
    end
  end

  // ----------------------------------------
  // Counter on the falling CPU edge
  // ----------------------------------------
  // Write-to-low request is carried over as a level sampled on the fall
  reg loadReq_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loadReq_q <= 1'b0;
    else
      loadReq_q <= wrLow;
  end

  always @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q   <= `TCI_CNT_RESET;
      negFall_q <= 1'b0;
    end
    else if (loadReq_q)
    begin
      count_q   <= `TCI_CNT_RESET;
      negFall_q <= 1'b0;
    end
    else if (tick_q)
    begin
      count_q   <= count_q + 16'h0001;
      negFall_q <= (count_q == `TCI_CNT_MAX);
    end
    else
    begin
      negFall_q <= 1'b0;
    end
  end

  // Rollover seen once in the rising domain
  reg rollSeen_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rollSeen_q <= 1'b0;
    else
      rollSeen_q <= negFall_q;
  end
  wire rollEvent = negFall_q & ~rollSeen_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlOne_q <= `TCI_CTRL_RESET;
      ctrlTwo_q <= `TCI_CTRL_RESET;
    end
    else if (regWrEn)
    begin
      if (regAddr == `TCI_A_CTRL_ONE)
        ctrlOne_q <= regWrData;
      if (regAddr == `TCI_A_CTRL_TWO)
        ctrlTwo_q <= regWrData;
    end
  end

  // ----------------------------------------
  // Coherent 16-bit read buffer
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowBuf_q    <= 8'h00;
      lowFrozen_q <= 1'b0;
    end
    else if (rdHigh && !lowFrozen_q)
    begin
      lowBuf_q    <= count_q[7:0];
      lowFrozen_q <= 1'b1;
    end
    else if (rdLow)
    begin
      lowFrozen_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Captures, held off while a high byte is pending
  // ----------------------------------------
  // Channel one is reserved for the pulse modes
  wire cap1Take = cap1Edge & ~pulseModes & ~cap1Block_q;
  wire cap2Take = cap2Edge & ~cap2Block_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap1_q      <= 16'h0000;
      cap2_q      <= 16'h0000;
      cap1Block_q <= 1'b0;
      cap2Block_q <= 1'b0;
    end
    else
    begin
      if (cap1Take)
        cap1_q <= count_q;
      if (cap2Take)
        cap2_q <= count_q;
      if (rdCap1Hi)
        cap1Block_q <= 1'b1;
      else if (rdCap1Lo)
        cap1Block_q <= 1'b0;
      if (rdCap2Hi)
        cap2Block_q <= 1'b1;
      else if (rdCap2Lo)
        cap2Block_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Flags with two-step clear; a new event wins
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rolloverFlag_q <= 1'b0;
      cap1Flag_q     <= 1'b0;
      cap2Flag_q     <= 1'b0;
      rollArm_q      <= 1'b0;
      cap1Arm_q      <= 1'b0;
      cap2Arm_q      <= 1'b0;
    end
    else
    begin
      // Arm on a flags read that sees the bit set
      if (rdFlags && rolloverFlag_q)
        rollArm_q <= 1'b1;
      else if (accCntLo)
        rollArm_q <= 1'b0;
      if (rdFlags && cap1Flag_q)
        cap1Arm_q <= 1'b1;
      else if (accCap1Lo)
        cap1Arm_q <= 1'b0;
      if (rdFlags && cap2Flag_q)
        cap2Arm_q <= 1'b1;
      else if (accCap2Lo)
        cap2Arm_q <= 1'b0;

      // Shadow low access is not decoded here, so it never clears
      if (rollEvent)
        rolloverFlag_q <= 1'b1;
      else if (accCntLo && rollArm_q)
        rolloverFlag_q <= 1'b0;
      if (cap1Take)
        cap1Flag_q <= 1'b1;
      else if (accCap1Lo && cap1Arm_q)
        cap1Flag_q <= 1'b0;
      if (cap2Take)
        cap2Flag_q <= 1'b1;
      else if (accCap2Lo && cap2Arm_q)
        cap2Flag_q <= 1'b0;
    end
  end

  // Requests stay pending in the flags until enable and mask allow
  assign rolloverIrq = rolloverFlag_q & ctrlOne_q[`TCI_C1_ROLLIE] & ~globalMask;
  assign captureIrq  = (cap1Flag_q | cap2Flag_q) & ctrlOne_q[`TCI_C1_CAPIE]
                       & ~globalMask;

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  reg [7:0] rdMux;
  always @*
  begin
    case (regAddr)
      `TCI_A_CTRL_ONE: rdMux = ctrlOne_q;
      `TCI_A_CTRL_TWO: rdMux = ctrlTwo_q;
      `TCI_A_FLAGS:    rdMux = {cap1Flag_q, 1'b0, rolloverFlag_q, cap2Flag_q, 4'h0};
      `TCI_A_CAP1_HI:  rdMux = cap1_q[15:8];
      `TCI_A_CAP1_LO:  rdMux = cap1_q[7:0];
      `TCI_A_CAP2_HI:  rdMux = cap2_q[15:8];
      `TCI_A_CAP2_LO:  rdMux = cap2_q[7:0];
      `TCI_A_CNT_HI:   rdMux = count_q[15:8];
      `TCI_A_SHD_HI:   rdMux = count_q[15:8];
      `TCI_A_CNT_LO:   rdMux = lowFrozen_q ? lowBuf_q : count_q[7:0];
      `TCI_A_SHD_LO:   rdMux = lowFrozen_q ? lowBuf_q : count_q[7:0];
      default:         rdMux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 8'h00;
    else if (regRdEn)
      regRdData <= rdMux;
    else
      regRdData <= 8'h00;
  end

endmodule // tci_timer

// [rtl/tci_defs.vh]
// Constants for the timer counter with input capture
`ifndef TCI_DEFS_VH
`define TCI_DEFS_VH

// ----------------------------------------
// Register addresses (byte wide, one per address)
// ----------------------------------------
`define TCI_ADDR_W        4
`define TCI_A_CTRL_ONE    4'h0
`define TCI_A_CTRL_TWO    4'h1
`define TCI_A_FLAGS       4'h2
`define TCI_A_CAP1_HI     4'h3
`define TCI_A_CAP1_LO     4'h4
`define TCI_A_CNT_HI      4'h5
`define TCI_A_CNT_LO      4'h6
`define TCI_A_SHD_HI      4'h7
`define TCI_A_SHD_LO      4'h8
`define TCI_A_CAP2_HI     4'h9
`define TCI_A_CAP2_LO     4'hA

// ----------------------------------------
// Field positions
// ----------------------------------------
// Control one
`define TCI_C1_CAPIE      7
`define TCI_C1_ROLLIE     5
`define TCI_C1_CAP1EDGE   1
// Control two
`define TCI_C2_SPM        4
`define TCI_C2_PWM        5
`define TCI_C2_CKHI       3
`define TCI_C2_CKLO       2
`define TCI_C2_CAP2EDGE   1
`define TCI_C2_EXTEDGE    0
// Flags
`define TCI_F_CAP1        7
`define TCI_F_ROLL        5
`define TCI_F_CAP2        4

// ----------------------------------------
// Values
// ----------------------------------------
`define TCI_CNT_RESET     16'hFFFC
`define TCI_CNT_MAX       16'hFFFF
`define TCI_CTRL_RESET    8'h00
`define TCI_DIV2_MASK     3'h1
`define TCI_DIV4_MASK     3'h3
`define TCI_DIV8_MASK     3'h7
`define TCI_CK_DIV4       2'h0
`define TCI_CK_DIV2       2'h1
`define TCI_CK_DIV8       2'h2
`define TCI_CK_EXT        2'h3

`endif

// [rtl/tci_edge_sync.v]
// Two-flop synchroniser with selectable edge detector
`timescale 1ns/10ps

module tci_edge_sync
(
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Asynchronous input and edge choice
  input  wire pinIn,
  input  wire riseSel,
  // Detected active edge, one-cycle pulse
  output wire edgePulse
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ----------------------------------------
  // Synchronise then remember last level
  // ----------------------------------------
  // Reset to 1 so an absent pin, held high, makes no false edge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge on the synchronised level only
  assign edgePulse = riseSel ? (sync_q & ~prev_q) : (~sync_q & prev_q);

endmodule // tci_edge_sync

// [tb/tci_timer_props.sv]
// Concurrent checks on the timer register port and request outputs
`timescale 1ns/10ps
`include "tci_defs.vh"

module tci_timer_props
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Register port
  input wire logic [`TCI_ADDR_W-1:0] regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWrEn,
  input wire logic                   regRdEn,
  input wire logic [7:0]             regRdData,
  // Processor state and pins
  input wire logic                   globalMask,
  input wire logic                   haltMode,
  input wire logic                   capture_input_one,
  input wire logic                   capture_input_two,
  input wire logic                   ext_count_clock_pin,
  // Requests
  input wire logic                   rolloverIrq,
  input wire logic                   captureIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Register port answers
  // ------------------------------------------------------------
  // Read data stands for one cycle only, unmapped reads give zero
  rd_idle_zero_a: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property (regRdEn && regAddr > `TCI_A_CAP2_LO |=> regRdData == 8'h00)
    else $error("unmapped read returned nonzero data");
  // A control one write reads back on the next access
  ctrl_readback_a: assert property ((regWrEn && regAddr == `TCI_A_CTRL_ONE) ##1
    (regRdEn && regAddr == `TCI_A_CTRL_ONE) |=> regRdData == $past(regWrData, 2))
    else $error("control one read back differs from written value");
  // A low byte write loads FFFC, so the high byte then reads FF
  load_value_a: assert property ((regWrEn && (regAddr == `TCI_A_CNT_LO || regAddr ==
    `TCI_A_SHD_LO)) ##2 (regRdEn && regAddr == `TCI_A_CNT_HI) |=> regRdData == 8'hFF)
    else $error("counter high byte not FF after low byte write");
  // Repeated capture high reads see the same blocked value
  cap_block_a: assert property ((regRdEn && regAddr == `TCI_A_CAP2_HI) ##1 (!regRdEn)[*3]
    ##1 (regRdEn && regAddr == `TCI_A_CAP2_HI) |=> regRdData == $past(regRdData, 4))
    else $error("capture high byte changed while blocked");
  // Halt freezes the count, live low reads repeat
  halt_hold_a: assert property (haltMode[*3] ##0 (regRdEn && regAddr == `TCI_A_CNT_LO)
    ##1 (haltMode && regRdEn && regAddr == `TCI_A_CNT_LO)[*2] |=> $stable(regRdData))
    else $error("counter moved during halt");

  // ------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------
  // The global mask always wins over a pending flag
  roll_mask_a: assert property (rolloverIrq |-> !globalMask)
    else $error("rollover request while masked");
  cap_mask_a: assert property (captureIrq |-> !globalMask)
    else $error("capture request while masked");
  // Outside writes, only a counter low read or the global mask may drop a pending rollover request
  roll_hold_a: assert property (rolloverIrq && !regWrEn && !(regRdEn && regAddr ==
    `TCI_A_CNT_LO) |=> globalMask || rolloverIrq)
    else $error("rollover request dropped without counter low access");
  // Outside writes, only a capture low read or the global mask may drop a pending capture request
  cap_hold_a: assert property (captureIrq && !regWrEn && !(regRdEn && (regAddr ==
    `TCI_A_CAP1_LO || regAddr == `TCI_A_CAP2_LO)) |=> globalMask || captureIrq)
    else $error("capture request dropped without capture low access");
endmodule // tci_timer_props

bind tci_timer tci_timer_props tci_timer_props_i
(
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .globalMask(globalMask), .haltMode(haltMode),
  .capture_input_one(capture_input_one), .capture_input_two(capture_input_two),
  .ext_count_clock_pin(ext_count_clock_pin),
  .rolloverIrq(rolloverIrq), .captureIrq(captureIrq)
);

// [tb/tci_pin_model.sv]
// Far-side model of the capture pins and the external count clock
`timescale 1ns/10ps

module tci_pin_model
(
  // Clock used only to pace the edges
  input  wire logic clk,
  // Pins into the timer
  output logic      capOnePin,
  output logic      capTwoPin,
  output logic      extClkPin
);
  // Idle pins rest high, as absent pins do
  initial
  begin
    capOnePin = 1'b1;
    capTwoPin = 1'b1;
    extClkPin = 1'b1;
  end

  // Toggle a capture pin, then wait out the synchroniser
  task automatic toggleCap(input int ch);
    @(posedge clk);
    if (ch == 1)
      capOnePin <= ~capOnePin;
    else
      capTwoPin <= ~capTwoPin;
    repeat (6) @(posedge clk);
  endtask

  // Like edges stay six CPU cycles apart, slower than a quarter rate
  task automatic toggleExt(input int n);
    repeat (n)
    begin
      @(posedge clk);
      extClkPin <= ~extClkPin;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
endmodule // tci_pin_model

// [tb/tb_top.sv]
// Self-checking bench for the timer counter with input capture
`timescale 1ns/10ps
`include "tci_defs.vh"

module tb_top;
  logic                   clk;
  logic                   rst_n;
  logic [`TCI_ADDR_W-1:0] regAddr;
  logic [7:0]             regWrData;
  logic                   regWrEn;
  logic                   regRdEn;
  wire  [7:0]             regRdData;
  logic                   globalMask;
  logic                   haltMode;
  wire                    capOnePin;
  wire                    capTwoPin;
  wire                    extClkPin;
  wire                    rolloverIrq;
  wire                    captureIrq;
  int                     errors;
  int                     checks_done;
  logic [7:0]             valA;
  logic [7:0]             valB;
  logic [7:0]             snap;
  logic [7:0]             deltas [0:1];
  logic [1:0]             selTab [0:2] = '{`TCI_CK_DIV2, `TCI_CK_DIV4, `TCI_CK_DIV8};
  int                     divTab [0:2] = '{2, 4, 8};

  // Design and far-side pins
  tci_timer tci_timer_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .globalMask(globalMask),
    .haltMode(haltMode), .capture_input_one(capOnePin), .capture_input_two(capTwoPin),
    .ext_count_clock_pin(extClkPin), .rolloverIrq(rolloverIrq), .captureIrq(captureIrq));
  tci_pin_model tci_pin_model_i (.clk(clk), .capOnePin(capOnePin), .capTwoPin(capTwoPin),
    .extClkPin(extClkPin));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask
  // Data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #200000;
    errors++;
    report_and_stop;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    globalMask = 1'b1;
    haltMode = 1'b0;
    errors = 0;
    checks_done = 0;
    idle(16);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`TCI_A_CTRL_ONE, valA); chk(valA, `TCI_CTRL_RESET);
    rd(`TCI_A_CTRL_TWO, valA); chk(valA, `TCI_CTRL_RESET);
    rd(4'hF, valA); chk(valA, 8'h00);
    // Count rate per prescaler over 65 cycles between live reads
    for (int i = 0; i < 3; i++)
    begin
      wr(`TCI_A_CTRL_TWO, {4'h0, selTab[i], 2'b00});
      rd(`TCI_A_CNT_LO, valA);
      idle(64);
      rd(`TCI_A_CNT_LO, valB);
      snap = valB - valA;
      chk(snap >= 8'(65 / divTab[i] - 1) && snap <= 8'(65 / divTab[i] + 1), 1);
    end
    $display("Test prescaler done");
    // Buffered low byte survives a second high read, then reads go live
    wr(`TCI_A_CTRL_TWO, 8'h04);
    rd(`TCI_A_CNT_HI, valA);
    idle(40);
    rd(`TCI_A_CNT_HI, valA);
    rd(`TCI_A_CNT_LO, valA);
    rd(`TCI_A_CNT_LO, valB);
    snap = valB - valA;
    chk(snap >= 8'd20 && snap <= 8'd23, 1);
    $display("Test coherent read done");
    // Load, roll over while masked, then the two-step clear
    wr(`TCI_A_CTRL_ONE, 8'h20);
    wr(`TCI_A_CNT_LO, 8'h5A);
    idle(1);
    rd(`TCI_A_CNT_HI, valA); chk(valA, 8'hFF);
    rd(`TCI_A_CNT_LO, valA); chk(valA[7:2], 6'h3F);
    idle(16);
    chk(rolloverIrq, 1'b0);
    rd(`TCI_A_CNT_LO, valA);
    globalMask <= 1'b0;
    rd(`TCI_A_FLAGS, valA); chk(valA[`TCI_F_ROLL], 1'b1);
    chk(rolloverIrq, 1'b1);
    rd(`TCI_A_SHD_LO, valA); chk(rolloverIrq, 1'b1);
    rd(`TCI_A_FLAGS, valA);
    rd(`TCI_A_CNT_LO, valA); chk(rolloverIrq, 1'b0);
    $display("Test rollover done");
    // External clock: seven toggles from high give four falls, three rises
    for (int e = 0; e < 2; e++)
    begin
      wr(`TCI_A_CTRL_TWO, {4'h0, 2'b11, 1'b0, e[0]});
      rd(`TCI_A_CNT_LO, valA);
      tci_pin_model_i.toggleExt(7);
      rd(`TCI_A_CNT_LO, valB);
      deltas[e] = valB - valA;
      wr(`TCI_A_CTRL_TWO, 8'h04);
      tci_pin_model_i.toggleExt(1);
    end
    chk(deltas[0] + deltas[1], 16'd7);
    chk(deltas[0] != deltas[1], 1);
    $display("Test external clock done");
    // Captures on a frozen count give exact values; divide by 8 keeps channel one
    wr(`TCI_A_CTRL_TWO, 8'h08);
    wr(`TCI_A_CTRL_ONE, 8'h82);
    rd(`TCI_A_CTRL_ONE, valB); chk(valB, 8'h82);
    haltMode <= 1'b1;
    idle(2);
    rd(`TCI_A_CNT_HI, valA);
    rd(`TCI_A_CNT_LO, snap);
    rd(`TCI_A_CNT_LO, valB);
    rd(`TCI_A_CNT_LO, valB);
    rd(`TCI_A_CNT_LO, valB); chk(valB, snap);
    tci_pin_model_i.toggleCap(1);
    rd(`TCI_A_FLAGS, valB); chk(valB[`TCI_F_CAP1], 1'b0);
    tci_pin_model_i.toggleCap(1);
    chk(captureIrq, 1'b1);
    rd(`TCI_A_FLAGS, valB); chk(valB[`TCI_F_CAP1], 1'b1);
    rd(`TCI_A_CAP1_HI, valB); chk(valB, valA);
    rd(`TCI_A_CAP1_LO, valB); chk(valB, snap);
    chk(captureIrq, 1'b0);
    tci_pin_model_i.toggleCap(2);
    rd(`TCI_A_FLAGS, valB); chk(valB[`TCI_F_CAP2], 1'b1);
    rd(`TCI_A_CAP2_HI, valB); chk(valB, valA);
    haltMode <= 1'b0;
    idle(3);
    rd(`TCI_A_CAP2_HI, valB); chk(valB, valA);
    tci_pin_model_i.toggleCap(2);
    tci_pin_model_i.toggleCap(2);
    rd(`TCI_A_CAP2_LO, valB); chk(valB, snap);
    // Single-pulse mode leaves channel one without captures
    wr(`TCI_A_CTRL_TWO, 8'h14);
    tci_pin_model_i.toggleCap(1);
    tci_pin_model_i.toggleCap(1);
    rd(`TCI_A_FLAGS, valB); chk(valB[`TCI_F_CAP1], 1'b0);
    $display("Test capture done");
    // Reset in mid-run restarts from the reset count with controls cleared
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`TCI_A_CNT_HI, valA);
    rd(`TCI_A_CNT_LO, valB); chk({valA, valB}, `TCI_CNT_RESET);
    rd(`TCI_A_CTRL_TWO, valB); chk(valB, `TCI_CTRL_RESET);
    $display("Test reset done");
    report_and_stop;
  end
endmodule // tb_top
